// ===== bench/fdci_drive_model.sv
// fdci_drive_model: drive and data separator on the core's disk side.
// assumes the bench raises spin for a track, send_id for one id field.
module fdci_drive_model
  import fdci_pkg::*;
#(
  parameter fdci_id_t ID_VAL = '0  // id field handed over
)
(
  input  wire logic  ref_clk,      // controller clock
  input  wire logic  spin,         // stream a track
  input  wire logic  send_id,      // deliver one id field
  input  wire logic  kick,         // extra index level
  output fdci_disk_t disk,         // byte stream
  output logic       index_pulse,  // index level
  output fdci_id_t   id_field,     // id field
  output logic       id_valid      // id strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] pos_r  = 6'h00;
  logic [7:0] last_r = 8'h00;
  always @(posedge ref_clk) begin
    pos_r  <= spin ? pos_r + 6'h01 : 6'h00;
    last_r <= disk.data;
  end
  // byte every fourth cycle, mark on the third byte; idle lines toggle
  assign disk = '{valid:      spin && pos_r[1:0] == 2'h0,
                  index_mark: spin && pos_r == 6'h08,
                  data:       spin ? ({2'h0, pos_r} ^ 8'hA5) : ~last_r};
  assign index_pulse     = kick || (spin && pos_r < 6'h04);
  assign id_valid        = send_id;
  assign id_field        = send_id ? ID_VAL : ~ID_VAL;
endmodule : fdci_drive_model

// ===== bench/tb.sv
// tb: command sequences against the core with the drive model behind it.
// assumes inputs change on the falling edge, outputs settle one edge later.
module tb;
  import fdci_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam fdci_id_t EXP_ID = 48'h1A_01_07_02_C3_5E;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_wr = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic       status_rd = 1'b0;
  logic       data_rd = 1'b0;
  logic       drive_ready = 1'b1;
  logic       spin = 1'b0;
  logic       send_id = 1'b0;
  logic       kick = 1'b0;
  fdci_disk_t disk;
  fdci_id_t   id_field;
  logic       index_pulse, id_valid, data_synced, irq_line, read_gate, busy;
  logic [7:0] status, data_out;
  int         n_errors = 0;
  int         tests_run = 0;
  always #20 ref_clk = ~ref_clk;
  fdci_core dut_u (.ref_clk(ref_clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
    .status_rd(status_rd), .data_rd(data_rd), .drive_ready(drive_ready),
    .index_pulse(index_pulse), .disk(disk), .id_field(id_field), .id_valid(id_valid),
    .status(status), .data_out(data_out), .data_synced(data_synced),
    .irq_line(irq_line), .read_gate(read_gate), .busy(busy));
  fdci_drive_model #(.ID_VAL(EXP_ID)) drv_u (.ref_clk(ref_clk), .spin(spin),
    .send_id(send_id), .kick(kick), .disk(disk), .index_pulse(index_pulse),
    .id_field(id_field), .id_valid(id_valid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic cmd(input logic [7:0] b);
    cmd_data = b;
    cmd_wr = 1'b1;
    cyc(1);
    cmd_wr = 1'b0;
    cyc(2);
  endtask : cmd
  task automatic srd;
    status_rd = 1'b1;
    cyc(1);
    status_rd = 1'b0;
    cyc(2);
  endtask : srd
  task automatic drd;
    data_rd = 1'b1;
    cyc(1);
    data_rd = 1'b0;
    cyc(2);
  endtask : drd
  ////////////////////////////////////////////////////////////////////////////
  // a gate pulse between checks would otherwise slip by
  always @(negedge ref_clk) if (!rst && read_gate !== 1'b0) begin
    n_errors++;
    $display("Error at %0t: read gate active", $time);
  end
  initial begin
    #(40 * 2000);
    n_errors++;
    end_of_test();
  end
  initial begin
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk(status, STAT_RESET);
    drive_ready = 1'b0;
    cmd(8'hC0);
    chk(irq_line, 1'b1);
    chk(status[STAT_NOT_READY], 1'b1);
    chk(busy, 1'b0);
    srd();
    chk(irq_line, 1'b0);
    drive_ready = 1'b1;
    cmd(8'hC0);
    chk(busy, 1'b1);
    send_id = 1'b1;
    cyc(1);
    send_id = 1'b0;
    for (int i = 0; i < 8 && status[STAT_DRQ] !== 1'b1; i++) cyc(1);
    cyc(2);
    for (int k = 0; k < ID_BYTES; k++) begin
      chk(data_out, EXP_ID[47 - 8 * k -: 8]);
      drd();
    end
    chk(busy, 1'b0);
    chk(irq_line, 1'b1);
    srd();
    chk(irq_line, 1'b0);
    cmd(8'hC0);
    cmd(8'hD0);
    chk(busy, 1'b0);
    chk(irq_line, 1'b0);
    spin = 1'b1;
    cmd(8'hE0);
    chk(data_synced, 1'b0);
    chk(read_gate, 1'b0);
    cyc(11);
    chk(data_out, 8'hA9);
    chk(data_synced, 1'b1);
    for (int i = 0; i < 100 && busy !== 1'b0; i++) cyc(1);
    chk(busy, 1'b0);
    chk(irq_line, 1'b1);
    spin = 1'b0;
    srd();
    cmd(8'hD8);
    chk(irq_line, 1'b1);
    srd();
    chk(irq_line, 1'b1);
    cmd(8'hD0);
    chk(irq_line, 1'b0);
    for (int b = 0; b < 3; b++) begin
      drive_ready = (b != 0);
      cyc(2);
      cmd(8'hD0 | (8'h01 << b));
      chk(irq_line, 1'b0);
      if (b == 2) kick = 1'b1;
      else drive_ready = ~drive_ready;
      cyc(2);
      chk(irq_line, 1'b1);
      kick = 1'b0;
      if (b != 0) srd();
      else cmd(8'hD0);
      chk(irq_line, 1'b0);
    end
    drive_ready = 1'b1;
    cmd(8'hD6);
    kick = 1'b1;
    cyc(2);
    kick = 1'b0;
    chk(irq_line, 1'b1);
    srd();
    drive_ready = 1'b0;
    cyc(2);
    chk(irq_line, 1'b1);
    cmd(8'hD0);
    cmd(8'h00);
    chk(irq_line, 1'b1);
    chk(status[STAT_NOT_READY], 1'b1);
    chk(busy, 1'b0);
    srd();
    drive_ready = 1'b1;
    cmd(8'h80);
    chk(status, STAT_RESET);
    chk(irq_line, 1'b1);
    cmd(8'hD4);
    chk(irq_line, 1'b0);
    end_of_test();
  end
endmodule : tb

// ===== hdl/fdci_core.sv
// fdci_core: read-track, read-address and forced-interrupt command handling.
// assumes host strobes are one cycle wide and synchronous to ref_clk.
//
// How it works
// - read track passes every raw disk byte to the data register.
// - bytes before the index mark are flagged not synchronised.
// - read gate is held low through read track.
// - read address gives track, side, sector, length, crc1, crc2 in order.
// - type II/III with drive not ready: refuse, irq, not-ready bit set.
// - force-interrupt low bits pick ready rise, ready fall, index, immediate.
// - force-interrupt always ends the running command and clears busy.
// - an enabled condition raises the irq line.
// - force-interrupt with no conditions ends commands, makes no irq.
// - ordinary irq clears on status read or command write.
// - immediate irq persists until a zero-condition force-interrupt.
// - enabled conditions are ORed and stay armed; each one fires every time.
// - completion clears busy and raises irq; status read drops it.
// - type I commands run even when the drive is not ready.
module fdci_core
  import fdci_pkg::*;
(
  input  wire logic       ref_clk,        // 25 MHz controller clock
  input  wire logic       rst,            // synchronous reset, high
  input  wire logic       cmd_wr,         // command register write strobe
  input  wire logic [7:0] cmd_data,       // command byte
  input  wire logic       status_rd,      // status register read strobe
  input  wire logic       data_rd,        // data register read strobe
  input  wire logic       drive_ready,    // drive ready level
  input  wire logic       index_pulse,    // index hole level
  input  wire fdci_disk_t disk,           // raw byte stream from separator
  input  wire fdci_id_t   id_field,       // decoded id field
  input  wire logic       id_valid,       // id field present, one cycle
  output logic      [7:0] status,         // status register
  output logic      [7:0] data_out,       // data register
  output logic            data_synced,    // data byte taken at or after index mark
  output logic            irq_line,       // interrupt request
  output logic            read_gate,      // read gate to separator
  output logic            busy            // busy bit copy
);
  fdci_regs_t r_r, r_nxt;
  logic [7:0] id_byte;
  logic       id_load;

  fdci_id_mem u_id_mem (
    .ref_clk (ref_clk),
    .load    (id_load),
    .id_in   (id_field),
    .rd_idx  (r_r.id_idx),
    .rd_data (id_byte)
  );

  //////////////////////////////////////////////////////////////////////////
  logic rise_rdy, fall_rdy, idx_edge, cond_hit, is_fi, is_t23, zero_cond;
  logic [3:0] opc;

  always_comb begin
    opc       = cmd_data[7:4];
    is_fi     = cmd_wr && (opc == OPC_FORCE_INT);
    is_t23    = cmd_wr && opc[3] && !is_fi;        // type I has msb clear
    zero_cond = (cmd_data[3:0] == 4'h0);
    rise_rdy  = drive_ready && !r_r.ready_prev;
    fall_rdy  = !drive_ready && r_r.ready_prev;
    idx_edge  = index_pulse && !r_r.index_prev;
    cond_hit  = (r_r.cond[BIT_NRDY_RDY] && rise_rdy)
             || (r_r.cond[BIT_RDY_NRDY] && fall_rdy)
             || (r_r.cond[BIT_INDEX] && idx_edge);
  end

  always_comb begin
    r_nxt            = r_r;
    id_load          = 1'b0;
    r_nxt.ready_prev = drive_ready;
    r_nxt.index_prev = index_pulse;
    // ordinary request drops on status read or command write
    if ((status_rd || cmd_wr) && !r_r.irq_sticky) begin
      r_nxt.irq = 1'b0;
    end
    if (data_rd) begin
      r_nxt.drq = 1'b0;
    end
    case (r_r.state)
      FDCI_TRACK: begin
        if (disk.valid) begin
          if (disk.index_mark) begin
            r_nxt.synced = 1'b1;
          end
          r_nxt.drq  = 1'b1;
          r_nxt.dout = disk.data;
        end
        if (idx_edge && r_r.synced) begin
          r_nxt.state = FDCI_IDLE;                  // one revolution done
          r_nxt.status[STAT_BUSY] = 1'b0;
          r_nxt.irq = 1'b1;
        end
      end
      FDCI_ADDR: begin
        // memory port is registered: a byte lands two edges after id_idx moves
        r_nxt.dout = id_byte;
        if (id_valid && !r_r.synced) begin
          id_load      = 1'b1;
          r_nxt.synced = 1'b1;
          r_nxt.id_idx = 3'h0;
          r_nxt.drq    = 1'b1;
        end else if (r_r.synced && data_rd) begin
          if (r_r.id_idx == ID_LAST) begin
            r_nxt.state = FDCI_IDLE;
            r_nxt.status[STAT_BUSY] = 1'b0;
            r_nxt.irq = 1'b1;
          end else begin
            r_nxt.id_idx = r_r.id_idx + 3'h1;
            r_nxt.drq    = 1'b1;
          end
        end
      end
      FDCI_IDLE: begin
      end
      default: r_nxt.state = FDCI_IDLE;
    endcase
    if (cond_hit) begin
      r_nxt.irq = 1'b1;
    end
    if (is_fi) begin
      r_nxt.state = FDCI_IDLE;
      r_nxt.status[STAT_BUSY] = 1'b0;
      r_nxt.drq   = 1'b0;
      r_nxt.cond  = cmd_data[3:0];
      if (zero_cond) begin
        r_nxt.irq        = cond_hit;
        r_nxt.irq_sticky = 1'b0;
      end
      if (cmd_data[BIT_IMMED]) begin
        r_nxt.irq        = 1'b1;
        r_nxt.irq_sticky = 1'b1;
      end
    end else if (is_t23 && r_r.state == FDCI_IDLE) begin
      r_nxt.status = STAT_RESET;
      if (!drive_ready) begin
        r_nxt.status[STAT_NOT_READY] = 1'b1;
        r_nxt.irq = 1'b1;
      end else if (opc == OPC_READ_ADDR || opc == OPC_READ_TRACK) begin
        r_nxt.state  = (opc == OPC_READ_TRACK) ? FDCI_TRACK : FDCI_ADDR;
        r_nxt.synced = 1'b0;
        r_nxt.status[STAT_BUSY] = 1'b1;
      end else begin
        r_nxt.irq = 1'b1;                            // unsupported: complete at once
      end
    end else if (cmd_wr && !opc[3] && r_r.state == FDCI_IDLE) begin
      r_nxt.status = STAT_RESET;
      r_nxt.status[STAT_NOT_READY] = !drive_ready;
      r_nxt.irq = 1'b1;                              // type I head moves are outside
    end
    r_nxt.status[STAT_DRQ] = r_nxt.drq;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // ready history starts low; cond is zero after reset, so that false rise is masked
      r_r <= '{state: FDCI_IDLE, id_idx: 3'h0, synced: 1'b0, irq: 1'b0,
               irq_sticky: 1'b0, cond: 4'h0, ready_prev: 1'b0,
               index_prev: 1'b0, status: STAT_RESET, drq: 1'b0, dout: 8'h00};
    end else begin
      r_r <= r_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // one register feeds the data port for both commands
  assign data_out    = r_r.dout;
  assign data_synced = r_r.synced;
  assign status      = r_r.status;
  assign irq_line    = r_r.irq;
  assign busy        = r_r.status[STAT_BUSY];
  assign read_gate   = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  fi_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
    is_fi |=> !busy && r_r.state == FDCI_IDLE)
    else $error("busy not cleared by force interrupt");
  nrdy_refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
    (is_t23 && !drive_ready && r_r.state == FDCI_IDLE) |=> irq_line && status[STAT_NOT_READY]
      && !busy)
    else $error("not ready command not refused");
  rg_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    r_r.state == FDCI_TRACK |-> !read_gate)
    else $error("read gate active in read track");
  cond_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cond_hit && !is_fi) |=> irq_line)
    else $error("enabled condition missed");
  zero_noirq_a: assert property (@(posedge ref_clk) disable iff (rst)
    (is_fi && zero_cond && !cond_hit) |=> !irq_line)
    else $error("zero force interrupt raised irq");
  imm_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_line && r_r.irq_sticky && !(is_fi && zero_cond)) |=> irq_line)
    else $error("immediate irq dropped");
  clr_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    (status_rd && !r_r.irq_sticky && !cond_hit && r_r.state == FDCI_IDLE && !cmd_wr)
      |=> !irq_line)
    else $error("status read did not clear irq");
  idx_once_a: assert property (@(posedge ref_clk) disable iff (rst)
    idx_edge |-> !$past(index_pulse))
    else $error("index edge counted twice");
  t1_runs_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_wr && !opc[3] && r_r.state == FDCI_IDLE) |=> irq_line)
    else $error("type one refused");
  addr_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.state == FDCI_ADDR && r_r.synced && data_rd && r_r.id_idx == ID_LAST && !is_fi)
      |=> r_r.state == FDCI_IDLE && irq_line)
    else $error("read address did not end after six bytes");
  wr_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (is_fi && !cmd_data[BIT_IMMED] && !zero_cond && !r_r.irq_sticky && !cond_hit
      && r_r.state == FDCI_IDLE) |=> !irq_line)
    else $error("command write did not clear irq");
  trk_byte_a: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.state == FDCI_TRACK && disk.valid) |=> data_out == $past(disk.data))
    else $error("track byte not passed to data register");
  trk_sync_a: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.state == FDCI_TRACK && disk.valid && disk.index_mark) |=> data_synced)
    else $error("index mark did not mark stream synchronised");

  rd_addr_c: cover property (@(posedge ref_clk) disable iff (rst)
    r_r.state == FDCI_ADDR ##[1:50] r_r.state == FDCI_IDLE);
  rd_trk_c:  cover property (@(posedge ref_clk) disable iff (rst)
    r_r.state == FDCI_TRACK && disk.index_mark);
  imm_c:     cover property (@(posedge ref_clk) disable iff (rst)
    is_fi && cmd_data[BIT_IMMED]);
  t1_nrdy_c: cover property (@(posedge ref_clk) disable iff (rst)
    cmd_wr && !opc[3] && !drive_ready);
endmodule : fdci_core

// ===== hdl/fdci_id_mem.sv
// fdci_id_mem: six-entry id field store, registered read port.
// assumes the id field arrives as one word from the address mark decoder.
module fdci_id_mem
  import fdci_pkg::*;
(
  input  wire logic       ref_clk,  // controller clock
  input  wire logic       load,     // capture a whole id field
  input  wire fdci_id_t   id_in,    // id field from the disk
  input  wire logic [2:0] rd_idx,   // byte index to read
  output logic      [7:0] rd_data   // registered byte out
);
  logic [7:0] mem [ID_BYTES];
  logic [7:0] flat [ID_BYTES];

  assign flat[0] = id_in.track;
  assign flat[1] = id_in.side;
  assign flat[2] = id_in.sector;
  assign flat[3] = id_in.length_code;
  assign flat[4] = id_in.crc1;
  assign flat[5] = id_in.crc2;

  genvar g;
  generate
    for (g = 0; g < ID_BYTES; g++) begin : g_ent
      always_ff @(posedge ref_clk) begin
        if (load) begin
          mem[g] <= flat[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    rd_data <= (rd_idx <= ID_LAST) ? mem[rd_idx] : 8'h00;
  end
endmodule : fdci_id_mem

// ===== hdl/fdci_pkg.sv
// fdci_pkg: shared types and constants for the disk command interpreter.
// assumes one 25 MHz clock and a host that writes commands as plain strobes.
package fdci_pkg;

  localparam logic [3:0] CMD_TYPE_MASK  = 4'hF;
  localparam logic [3:0] OPC_RESTORE    = 4'h0;
  localparam logic [3:0] OPC_READ_ADDR  = 4'hC;
  localparam logic [3:0] OPC_FORCE_INT  = 4'hD;
  localparam logic [3:0] OPC_READ_TRACK = 4'hE;
  localparam int         ID_BYTES       = 6;
  localparam logic [2:0] ID_LAST        = 3'h5;
  localparam int         BIT_NRDY_RDY   = 0;
  localparam int         BIT_RDY_NRDY   = 1;
  localparam int         BIT_INDEX      = 2;
  localparam int         BIT_IMMED      = 3;
  localparam logic [7:0] STAT_RESET     = 8'h00;
  localparam int         STAT_BUSY      = 0;
  localparam int         STAT_DRQ       = 1;
  localparam int         STAT_NOT_READY = 7;

  typedef enum logic [1:0] {
    FDCI_IDLE  = 2'b00,
    FDCI_TRACK = 2'b01,
    FDCI_ADDR  = 2'b10
  } fdci_state_t;

  // one id field as it comes off the disk, in delivery order
  typedef struct packed {
    logic [7:0] track;
    logic [7:0] side;
    logic [7:0] sector;
    logic [7:0] length_code;
    logic [7:0] crc1;
    logic [7:0] crc2;
  } fdci_id_t;

  // raw byte stream from the separator
  typedef struct packed {
    logic       valid;
    logic       index_mark;
    logic [7:0] data;
  } fdci_disk_t;

  typedef struct packed {
    fdci_state_t state;
    logic [2:0]  id_idx;
    logic        synced;
    logic        irq;
    logic        irq_sticky;
    logic [3:0]  cond;
    logic        ready_prev;
    logic        index_prev;
    logic [7:0]  status;
    logic        drq;
    logic [7:0]  dout;
  } fdci_regs_t;

endpackage : fdci_pkg
